// file: fram_spi_device.sv
// Serial memory device end: command decoder, write latch, status and array
`timescale 1ns/100ps
`include "fram_spi_params.svh"
module fram_spi_device (
  // Clock and reset
  input  wire logic  REF_CLK,
  input  wire logic  ARST_N,
  input  wire logic  CE,
  // Serial link
  spi_link_if.device LINK,
  // Observation
  output logic [7:0] STATUS,
  output logic       WRITE_PULSE,
  output logic       SPI_MODE3
);
  logic [4:0]               pins;
  logic                     cs_n_s;
  logic                     sck_s;
  logic                     si_s;
  logic                     wp_n_s;
  logic                     hold_s;
  fram_spi_pkg::dev_state_t state;
  fram_spi_pkg::dev_state_t next_state;
  logic [2:0]               bit_cnt;
  logic [2:0]               next_bit_cnt;
  logic [7:0]               in_shift;
  logic [7:0]               next_in_shift;
  logic [7:0]               out_shift;
  logic [7:0]               next_out_shift;
  logic [`ADDR_W-1:0]       addr;
  logic [`ADDR_W-1:0]       next_addr;
  logic [`ADDR_W-1:0]       full_addr;
  logic                     is_read;
  logic                     next_is_read;
  logic                     out_valid;
  logic                     next_out_valid;
  logic                     write_latch_flag;
  logic                     next_write_latch_flag;
  logic                     wpen;
  logic                     next_wpen;
  logic [1:0]               bp;
  logic [1:0]               next_bp;
  logic                     mode3;
  logic                     next_mode3;
  logic                     so;
  logic                     next_so;
  logic                     so_oe;
  logic                     next_so_oe;
  logic                     sck_d;
  logic                     cs_d;
  logic [7:0]               next_status;
  logic                     next_write_pulse;
  logic                     sck_rise;
  logic                     sck_fall;
  logic [7:0]               rx_byte;
  logic                     mem_we;
  logic [7:0]               mem [0:`MEM_DEPTH-1];

  pin_sync #(.WIDTH(5)) u_sync (
    .clk    (REF_CLK),
    .arst_n (ARST_N),
    .ce     (CE),
    .din    ({LINK.cs_n, LINK.sck, LINK.si, LINK.wp_n, LINK.hold_n} ^ `SYNC_IDLE_INV),
    .dout   (pins)
  );
  assign {cs_n_s, sck_s, si_s, wp_n_s, hold_s} = pins ^ `SYNC_IDLE_INV;
  assign LINK.so    = so;
  assign LINK.so_oe = so_oe;

  function automatic logic [7:0] status_pack(input logic pen, input logic [1:0] b, input logic l);
    logic [7:0] s;
    s = `SR_RESET;
    s[`SR_WPEN] = pen;
    s[`SR_BP_HI:`SR_BP_LO] = b;
    s[`SR_LATCH] = l;
    return s;
  endfunction

  function automatic logic blocked(input logic [`ADDR_W-1:0] a, input logic [1:0] b);
    case (b)
      2'h0:    blocked = 1'b0;
      2'h1:    blocked = (a >= `BP_QUARTER);
      2'h2:    blocked = (a >= `BP_HALF);
      default: blocked = 1'b1;
    endcase
  endfunction

  always_comb begin
    next_state       = state;
    next_bit_cnt     = bit_cnt;
    next_in_shift    = in_shift;
    next_out_shift   = out_shift;
    next_addr        = addr;
    next_is_read     = is_read;
    next_out_valid   = out_valid;
    next_write_latch_flag = write_latch_flag;
    next_wpen        = wpen;
    next_bp          = bp;
    next_mode3       = mode3;
    next_so          = so;
    next_so_oe       = so_oe;
    next_write_pulse = 1'b0;
    mem_we           = 1'b0;
    rx_byte          = {in_shift[6:0], si_s};
    full_addr        = {addr[`ADDR_W-1:8], rx_byte};
    sck_rise         = !cs_n_s && hold_s && !sck_d && sck_s;
    sck_fall         = !cs_n_s && hold_s && sck_d && !sck_s;
    if (cs_d && !cs_n_s) begin
      next_mode3   = sck_s;
      next_state   = fram_spi_pkg::ST_OPCODE;
      next_bit_cnt = 3'h0;
    end else if (cs_n_s) begin
      if (!cs_d && state == fram_spi_pkg::ST_WRITE_DATA)
        next_write_latch_flag = 1'b0;
      next_state     = fram_spi_pkg::ST_OPCODE;
      next_bit_cnt   = 3'h0;
      next_out_valid = 1'b0;
      next_so_oe     = 1'b0;
    end else begin
      if (!hold_s)
        next_so_oe = 1'b0;
      if (sck_rise) begin
        next_in_shift = rx_byte;
        next_bit_cnt  = bit_cnt + 3'h1;
        if (bit_cnt == `LAST_BIT) begin
          case (state)
            fram_spi_pkg::ST_OPCODE: begin
              next_state = fram_spi_pkg::ST_IGNORE;
              case (rx_byte)
                `OP_SET_LATCH:   next_write_latch_flag = 1'b1;
                `OP_CLEAR_LATCH: next_write_latch_flag = 1'b0;
                `OP_STATUS_WRITE: next_state = fram_spi_pkg::ST_STATUS_WRITE;
                `OP_STATUS_READ: begin
                  next_out_shift = status_pack(wpen, bp, write_latch_flag);
                  next_out_valid = 1'b1;
                  next_state     = fram_spi_pkg::ST_STATUS_READ;
                end
                `OP_MEM_READ: begin
                  next_is_read = 1'b1;
                  next_state   = fram_spi_pkg::ST_ADDR_HI;
                end
                `OP_MEM_WRITE: begin
                  next_is_read = 1'b0;
                  next_state   = fram_spi_pkg::ST_ADDR_HI;
                end
                default: next_state = fram_spi_pkg::ST_IGNORE;
              endcase
            end
            fram_spi_pkg::ST_ADDR_HI: begin
              next_addr[`ADDR_W-1:8] = rx_byte[`ADDR_HI_W-1:0];
              next_state = fram_spi_pkg::ST_ADDR_LO;
            end
            fram_spi_pkg::ST_ADDR_LO: begin
              next_addr = full_addr;
              next_state = fram_spi_pkg::ST_WRITE_DATA;
              if (is_read) begin
                next_out_shift = mem[full_addr];
                next_out_valid = 1'b1;
                next_addr      = full_addr + `ADDR_W'(1);
                next_state     = fram_spi_pkg::ST_READ_DATA;
              end
            end
            fram_spi_pkg::ST_READ_DATA: begin
              next_out_shift = mem[addr];
              next_addr      = addr + `ADDR_W'(1);
            end
            fram_spi_pkg::ST_WRITE_DATA: begin
              // Written on the eighth rise; the wp pin plays no part here
              mem_we           = write_latch_flag && !blocked(addr, bp);
              next_write_pulse = mem_we;
              next_addr        = addr + `ADDR_W'(1);
            end
            fram_spi_pkg::ST_STATUS_WRITE: begin
              if (write_latch_flag && !(wpen && !wp_n_s)) begin
                next_wpen = rx_byte[`SR_WPEN];
                next_bp   = rx_byte[`SR_BP_HI:`SR_BP_LO];
              end
              next_write_latch_flag = 1'b0;
              next_state = fram_spi_pkg::ST_IGNORE;
            end
            fram_spi_pkg::ST_STATUS_READ: begin
              next_out_valid = 1'b0;
              next_state     = fram_spi_pkg::ST_IGNORE;
            end
            default: next_state = fram_spi_pkg::ST_IGNORE;
          endcase
        end
      end
      if (sck_fall) begin
        next_so_oe = out_valid;
        if (out_valid) begin
          next_so        = out_shift[7];
          next_out_shift = {out_shift[6:0], 1'b0};
        end
      end
    end
    next_status = status_pack(next_wpen, next_bp, next_write_latch_flag);
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state       <= fram_spi_pkg::ST_OPCODE;
      bit_cnt     <= 3'h0;
      in_shift    <= 8'h00;
      out_shift   <= 8'h00;
      addr        <= '0;
      is_read     <= 1'b0;
      out_valid   <= 1'b0;
      write_latch_flag <= 1'b0;
      wpen        <= 1'b0;
      bp          <= 2'h0;
      mode3       <= 1'b0;
      so          <= 1'b0;
      so_oe       <= 1'b0;
      sck_d       <= 1'b0;
      cs_d        <= 1'b1;
      STATUS      <= `SR_RESET;
      WRITE_PULSE <= 1'b0;
      SPI_MODE3   <= 1'b0;
    end else if (CE) begin
      state       <= next_state;
      bit_cnt     <= next_bit_cnt;
      in_shift    <= next_in_shift;
      out_shift   <= next_out_shift;
      addr        <= next_addr;
      is_read     <= next_is_read;
      out_valid   <= next_out_valid;
      write_latch_flag <= next_write_latch_flag;
      wpen        <= next_wpen;
      bp          <= next_bp;
      mode3       <= next_mode3;
      so          <= next_so;
      so_oe       <= next_so_oe;
      sck_d       <= sck_s;
      cs_d        <= cs_n_s;
      STATUS      <= next_status;
      WRITE_PULSE <= next_write_pulse;
      SPI_MODE3   <= next_mode3;
    end
  end

  // Array storage, no reset
  always_ff @(posedge REF_CLK) begin
    if (CE && mem_we)
      mem[addr] <= rx_byte;
  end
endmodule // fram_spi_device

// file: fram_spi_host.sv
// Host controller: Avalon-MM registers driving one serial frame per command
`timescale 1ns/100ps
`include "fram_spi_params.svh"
module fram_spi_host (
  // Clock and reset
  input  wire logic   REF_CLK,
  input  wire logic   ARST_N,
  input  wire logic   CE,
  // Avalon-MM slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Serial link
  spi_link_if.host    LINK
);
  logic                      so_s;
  fram_spi_pkg::host_state_t state;
  fram_spi_pkg::host_state_t next_state;
  logic [3:0]                timer;
  logic [3:0]                next_timer;
  logic [5:0]                bits_left;
  logic [5:0]                next_bits_left;
  logic [31:0]               tx;
  logic [31:0]               next_tx;
  logic [7:0]                rx;
  logic [7:0]                next_rx;
  logic [7:0]                opcode;
  logic [7:0]                next_opcode;
  logic [15:0]               addr;
  logic [15:0]               next_addr;
  logic [7:0]                wdata;
  logic [7:0]                next_wdata;
  logic [7:0]                rdata;
  logic [7:0]                next_rdata;
  logic                      mode3;
  logic                      next_mode3;
  logic                      wp_n;
  logic                      next_wp_n;
  logic                      busy;
  logic                      next_busy;
  logic                      cs_n;
  logic                      next_cs_n;
  logic                      sck;
  logic                      next_sck;
  logic                      mosi;
  logic                      next_mosi;
  logic [31:0]               next_readdata;
  logic                      next_waitreq;
  logic                      tick;
  logic                      wr_now;
  logic                      start;
  logic [7:0]                new_op;

  pin_sync #(.WIDTH(1)) u_sync (
    .clk    (REF_CLK),
    .arst_n (ARST_N),
    .ce     (CE),
    .din    (LINK.so),
    .dout   (so_s)
  );
  assign LINK.cs_n   = cs_n;
  assign LINK.sck    = sck;
  assign LINK.si     = mosi;
  assign LINK.wp_n   = wp_n;
  assign LINK.hold_n = 1'b1;

  always_comb begin
    next_state     = state;
    next_timer     = timer;
    next_bits_left = bits_left;
    next_tx        = tx;
    next_rx        = rx;
    next_opcode    = opcode;
    next_addr      = addr;
    next_wdata     = wdata;
    next_rdata     = rdata;
    next_mode3     = mode3;
    next_wp_n      = wp_n;
    next_busy      = busy;
    next_cs_n      = cs_n;
    next_sck       = sck;
    next_mosi      = mosi;
    next_readdata  = AVS_READDATA;
    next_waitreq   = !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
    wr_now         = AVS_WRITE && !AVS_WAITREQUEST;
    start          = wr_now && AVS_ADDRESS == `REG_CMD && !busy;
    new_op         = AVS_WRITEDATA[7:0];
    tick           = (timer == 4'h0);
    if (AVS_READ && AVS_WAITREQUEST) begin
      case (AVS_ADDRESS)
        `REG_CMD:    next_readdata = {23'h0, mode3, opcode};
        `REG_ADDR:   next_readdata = {16'h0, addr};
        `REG_WDATA:  next_readdata = {24'h0, wdata};
        `REG_STATUS: next_readdata = {16'h0, rdata, 7'h0, busy};
        `REG_PINS:   next_readdata = {31'h0, wp_n};
        default:     next_readdata = 32'h0;
      endcase
    end
    if (wr_now) begin
      case (AVS_ADDRESS)
        `REG_ADDR:  next_addr  = AVS_WRITEDATA[15:0];
        `REG_WDATA: next_wdata = AVS_WRITEDATA[7:0];
        `REG_PINS:  next_wp_n  = AVS_WRITEDATA[0];
        default:    next_wp_n  = wp_n;
      endcase
    end
    if (state != fram_spi_pkg::H_IDLE)
      next_timer = tick ? `SCK_HALF_M1 : timer - 4'h1;
    case (state)
      fram_spi_pkg::H_IDLE: begin
        next_sck = mode3;
        if (start) begin
          next_opcode = new_op;
          next_mode3  = AVS_WRITEDATA[8];
          next_sck    = AVS_WRITEDATA[8];
          // Opcode first; array commands add address and a data byte, status commands a data byte
          case (new_op)
            `OP_MEM_READ, `OP_MEM_WRITE: begin
              next_tx = {new_op, addr, wdata};
              next_bits_left = `BITS_MEM;
            end
            `OP_STATUS_READ, `OP_STATUS_WRITE: begin
              next_tx = {new_op, wdata, 16'h0};
              next_bits_left = `BITS_STATUS;
            end
            default: begin
              next_tx = {new_op, 24'h0};
              next_bits_left = `BITS_CMD;
            end
          endcase
          next_mosi  = new_op[7];
          next_busy  = 1'b1;
          next_timer = `SCK_HALF_M1;
          next_state = fram_spi_pkg::H_SETUP;
        end
      end
      fram_spi_pkg::H_SETUP: begin
        if (tick) begin
          // Clock settles at its idle level before select falls
          if (cs_n) begin
            next_cs_n  = 1'b0;
          end else if (mode3) begin
            next_sck   = 1'b0;
            next_state = fram_spi_pkg::H_LOW;
          end else begin
            next_sck   = 1'b1;
            next_rx    = {rx[6:0], so_s};
            next_state = fram_spi_pkg::H_HIGH;
          end
        end
      end
      fram_spi_pkg::H_LOW: begin
        if (tick) begin
          next_sck   = 1'b1;
          next_rx    = {rx[6:0], so_s};
          next_state = fram_spi_pkg::H_HIGH;
        end
      end
      fram_spi_pkg::H_HIGH: begin
        if (tick) begin
          if (bits_left == 6'h01) begin
            next_sck   = mode3;
            next_state = fram_spi_pkg::H_END;
          end else begin
            next_sck       = 1'b0;
            next_tx        = {tx[30:0], 1'b0};
            next_mosi      = tx[30];
            next_bits_left = bits_left - 6'h01;
            next_state     = fram_spi_pkg::H_LOW;
          end
        end
      end
      fram_spi_pkg::H_END: begin
        if (tick) begin
          next_cs_n  = 1'b1;
          next_state = fram_spi_pkg::H_GAP;
        end
      end
      fram_spi_pkg::H_GAP: begin
        if (tick) begin
          next_rdata = rx;
          next_busy  = 1'b0;
          next_state = fram_spi_pkg::H_IDLE;
        end
      end
      default: next_state = fram_spi_pkg::H_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state           <= fram_spi_pkg::H_IDLE;
      timer           <= 4'h0;
      bits_left       <= 6'h00;
      tx              <= 32'h0;
      rx              <= 8'h00;
      opcode          <= 8'h00;
      addr            <= 16'h0;
      wdata           <= 8'h00;
      rdata           <= 8'h00;
      mode3           <= 1'b0;
      wp_n            <= 1'b1;
      busy            <= 1'b0;
      cs_n            <= 1'b1;
      sck             <= 1'b0;
      mosi            <= 1'b0;
      AVS_READDATA    <= 32'h0;
      AVS_WAITREQUEST <= 1'b1;
    end else if (CE) begin
      state           <= next_state;
      timer           <= next_timer;
      bits_left       <= next_bits_left;
      tx              <= next_tx;
      rx              <= next_rx;
      opcode          <= next_opcode;
      addr            <= next_addr;
      wdata           <= next_wdata;
      rdata           <= next_rdata;
      mode3           <= next_mode3;
      wp_n            <= next_wp_n;
      busy            <= next_busy;
      cs_n            <= next_cs_n;
      sck             <= next_sck;
      mosi            <= next_mosi;
      AVS_READDATA    <= next_readdata;
      AVS_WAITREQUEST <= next_waitreq;
    end
  end
endmodule // fram_spi_host

// file: fram_spi_params.svh
// Constants shared by the serial memory device end and its host controller
`ifndef FRAM_SPI_PARAMS_SVH
`define FRAM_SPI_PARAMS_SVH

// Command codes
`define OP_SET_LATCH    8'h06
`define OP_CLEAR_LATCH  8'h04
`define OP_STATUS_READ  8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_MEM_READ     8'h03
`define OP_MEM_WRITE    8'h02

// Array geometry
`define MEM_DEPTH      8192
`define ADDR_W         13
`define ADDR_HI_W      5
`define LAST_BIT       3'h7

// Status byte fields
`define SR_WPEN        7
`define SR_BP_HI       3
`define SR_BP_LO       2
`define SR_LATCH       1
`define SR_RESET       8'h00

// Block protect lower bounds
`define BP_QUARTER     13'h1800
`define BP_HALF        13'h1000

// Host serial clock half period in REF_CLK cycles, minus one
`define SCK_HALF_M1    4'h7

// Frame lengths in bits
`define BITS_CMD       6'h08
`define BITS_STATUS    6'h10
`define BITS_MEM       6'h20

// Host register byte offsets
`define REG_CMD        5'h00
`define REG_ADDR       5'h04
`define REG_WDATA      5'h08
`define REG_STATUS     5'h0c
`define REG_PINS       5'h10

// Idle-high pins inverted around the synchroniser, so its zero reset reads idle
`define SYNC_IDLE_INV  5'h13

`endif

// file: fram_spi_pkg.sv
// Types for the serial memory device end and its host controller
package fram_spi_pkg;

  typedef enum logic [2:0] {
    ST_OPCODE       = 3'b000,
    ST_ADDR_HI      = 3'b001,
    ST_ADDR_LO      = 3'b010,
    ST_WRITE_DATA   = 3'b011,
    ST_READ_DATA    = 3'b100,
    ST_STATUS_WRITE = 3'b101,
    ST_STATUS_READ  = 3'b110,
    ST_IGNORE       = 3'b111
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_LOW   = 3'b010,
    H_HIGH  = 3'b011,
    H_END   = 3'b100,
    H_GAP   = 3'b101
  } host_state_t;

endpackage

// file: pin_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      dout <= '0;
    end else if (ce) begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // pin_sync

// file: spi_link_if.sv
// Serial link between the host controller and the memory device
`timescale 1ns/100ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic wp_n;
  logic hold_n;
  logic so;
  logic so_oe;

  modport device (input cs_n, input sck, input si, input wp_n, input hold_n, output so, output so_oe);
  modport host (output cs_n, output sck, output si, output wp_n, output hold_n, input so, input so_oe);
endinterface

// file: spi_link_sva.sv
// Protocol checker for the serial link between host controller and memory device
`timescale 1ns/100ps
`include "fram_spi_params.svh"
module spi_link_sva (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // Serial link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic       sck_q;
  logic       next_sck_q;
  logic [5:0] rises;
  logic [5:0] next_rises;
  logic [7:0] op;
  logic [7:0] next_op;

  // Count clock rises within a frame, capture the opcode
  always_comb begin
    next_sck_q = sck;
    next_rises = rises;
    next_op = op;
    if (cs_n) begin
      next_rises = 6'h00;
    end else if (sck && !sck_q && rises != 6'h3f) begin
      next_rises = rises + 6'h01;
      if (rises < `BITS_CMD) next_op = {op[6:0], si};
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sck_q <= 1'b0;
      rises <= 6'h00;
      op <= 8'h00;
    end else begin
      sck_q <= next_sck_q;
      rises <= next_rises;
      op <= next_op;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  a_oe_off_idle: assert property (cs_n [*5] |-> !so_oe) else $error("so_oe high while deselected");
  a_so_on_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
    else $error("so changed while sck high");
  a_oe_start_read: assert property ($rose(so_oe) |-> !cs_n && !sck &&
    ((op == `OP_STATUS_READ && rises == 6'h08) || (op == `OP_MEM_READ && rises == 6'h18)))
    else $error("so_oe started at wrong bit");
  a_oe_only_read: assert property (so_oe |-> op == `OP_STATUS_READ || op == `OP_MEM_READ)
    else $error("so_oe high outside a read");
  a_status_one_byte: assert property (so_oe && op == `OP_STATUS_READ |-> rises <= 6'h10)
    else $error("status read longer than one byte");
  a_si_stable_rise: assert property (!cs_n && $rose(sck) |-> $stable(si))
    else $error("si changed at sck rise");
  a_frame_gap: assert property ($rose(cs_n) |-> cs_n [*8]) else $error("frame gap too short");
  a_mode3_fall_first: assert property ($fell(cs_n) && sck |-> ##[1:16] !sck)
    else $error("sck did not fall first");
  a_frame_bits: assert property ($rose(cs_n) && !sck |-> rises ==
    ((op == `OP_STATUS_READ || op == `OP_STATUS_WRITE) ? `BITS_STATUS :
     (op == `OP_MEM_READ || op == `OP_MEM_WRITE) ? `BITS_MEM : `BITS_CMD))
    else $error("frame bit count wrong");

  c_status_read: cover property ($rose(so_oe) && op == `OP_STATUS_READ);
  c_mem_read: cover property ($rose(so_oe) && op == `OP_MEM_READ);
  c_mode3: cover property ($fell(cs_n) && sck);
endmodule // spi_link_sva

// file: tb_top.sv
// Bench: host registers drive frames into the memory device
`timescale 1ns/100ps
`include "fram_spi_params.svh"
module tb_top;
  logic        REF_CLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic [4:0]  AVS_ADDRESS = 5'h00;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic [7:0]  STATUS;
  logic        WRITE_PULSE;
  logic        SPI_MODE3;
  logic [31:0] rd;
  int          errors = 0;
  int          total_checks = 0;
  int          pulses = 0;

  spi_link_if link ();
  fram_spi_host u_fram_spi_host (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CE(1'b1), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .LINK(link));
  fram_spi_device u_fram_spi_device (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CE(1'b1), .LINK(link),
    .STATUS(STATUS), .WRITE_PULSE(WRITE_PULSE), .SPI_MODE3(SPI_MODE3));
  spi_link_sva u_spi_link_sva (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .cs_n(link.cs_n), .sck(link.sck),
    .si(link.si), .so(link.so), .so_oe(link.so_oe));

  initial begin
    forever #25 REF_CLK = ~REF_CLK;
  end

  always @(posedge REF_CLK) begin
    if (WRITE_PULSE === 1'b1) pulses <= pulses + 1;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One Avalon cycle, held until waitrequest is sampled low
  task av(input logic wr, input logic [4:0] a, input logic [31:0] d = 32'h0);
    @(posedge REF_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  // One serial frame, then poll until the host is idle
  task frame(input logic [8:0] cmd, input logic [15:0] a = 16'h0000, input logic [7:0] d = 8'h00);
    av(1'b1, `REG_ADDR, {16'h0, a});
    av(1'b1, `REG_WDATA, {24'h0, d});
    av(1'b1, `REG_CMD, {23'h0, cmd});
    do av(1'b0, `REG_STATUS); while (rd[0] !== 1'b0);
  endtask

  task status_read_cmd(input logic [7:0] exp);
    frame({1'b0, `OP_STATUS_READ});
    check("status byte", rd[15:8], exp);
  endtask

  initial begin
    repeat (2) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    check("reset status", STATUS, `SR_RESET);
    status_read_cmd(8'h00);
    frame({1'b0, `OP_SET_LATCH});
    check("latch set", STATUS, 8'h02);
    status_read_cmd(8'h02);
    frame({1'b0, `OP_CLEAR_LATCH});
    check("latch clear", STATUS, 8'h00);
    // Protect pin low must not block the array
    av(1'b1, `REG_PINS, 32'h0);
    frame({1'b0, `OP_SET_LATCH});
    frame({1'b0, `OP_MEM_WRITE}, 16'he123, 8'ha5);
    check("write pulses", pulses, 32'h1);
    check("latch auto clear", STATUS, 8'h00);
    frame({1'b0, `OP_MEM_WRITE}, 16'h0123, 8'h5a);
    check("refused write", pulses, 32'h1);
    frame({1'b1, `OP_MEM_READ}, 16'h0123);
    check("read back", rd[15:8], 8'ha5);
    check("mode 3", SPI_MODE3, 1'h1);
    frame(9'h0ff);
    check("undefined op", STATUS, 8'h00);
    check("mode 0", SPI_MODE3, 1'h0);
    av(1'b1, `REG_PINS, 32'h1);
    av(1'b0, `REG_PINS);
    check("protect pin", rd, 32'h00000001);
    frame({1'b0, `OP_SET_LATCH});
    frame({1'b0, `OP_STATUS_WRITE}, 16'h0000, 8'hff);
    check("status write", STATUS, 8'h8c);
    av(1'b1, `REG_PINS, 32'h0);
    frame({1'b0, `OP_SET_LATCH});
    frame({1'b0, `OP_STATUS_WRITE});
    status_read_cmd(8'h8c);
    av(1'b1, `REG_PINS, 32'h1);
    frame({1'b0, `OP_SET_LATCH});
    frame({1'b0, `OP_STATUS_WRITE});
    status_read_cmd(8'h00);
    end_of_test();
  end

  initial begin
    #2000000;
    errors++;
    end_of_test();
  end
endmodule // tb_top
